// ==== rtl/mls_consts.vh ====
// constants for the motion link sequencer: register offsets, fields, reset values, timing
// included by rtl/mls_sequencer.v only
`ifndef MLS_CONSTS_VH
`define MLS_CONSTS_VH
`define MLS_ADDR_ACT_THR_HI 8'h20
`define MLS_ADDR_ACT_THR_LO 8'h21
`define MLS_ADDR_ACT_TIMER 8'h22
`define MLS_ADDR_INACT_THR_HI 8'h23
`define MLS_ADDR_INACT_THR_LO 8'h24
`define MLS_ADDR_INACT_TMR_HI 8'h25
`define MLS_ADDR_INACT_TMR_LO 8'h26
`define MLS_ADDR_LINK_CTL 8'h27
`define MLS_ADDR_POWER_CONTROL 8'h2d
`define MLS_ADDR_STATUS 8'h0b
`define MLS_RST_REG 8'h00
// motion link control fields
`define MLS_ACTIVITY_ENABLE_FIELD_LSB 0
`define MLS_INACTIVITY_ENABLE_FIELD_LSB 2
`define MLS_LINKLOOP_LSB 4
`define MLS_EN_REFERENCED 2'h3
`define MLS_SEQ_DEFAULT 2'h0
`define MLS_SEQ_LINKED 2'h1
`define MLS_SEQ_LOOP 2'h3
// power control fields
`define MLS_MEAS_LSB 0
`define MLS_MEAS_ON 2'h3
`define MLS_AUTOSLEEP_BIT 2
`define MLS_LOW_NOISE_BIT 4
// status bits
`define MLS_ST_ACT_BIT 4
`define MLS_ST_INACT_BIT 5
`define MLS_ST_AWAKE_BIT 6
`define MLS_AWAKE_RESET 1'b1
// start-up delay before the first sample in measurement mode
`define MLS_STARTUP_MS 100
`define MLS_CLOCK_HZ 100000000
`define MLS_STARTUP_CYCLES (`MLS_STARTUP_MS * (`MLS_CLOCK_HZ / 1000))
`endif

// ==== rtl/mls_sequencer.v ====
// motion link sequencer: activity/inactivity sequencing, awake flag, autosleep control
// assumes one register port on this clock and detector events/samples from the same domain
//
// Overview of operation
// R01 - host must enable detectors; disabled after reset
// R02 - default mode: both run, events held until read
// R03 - linked: after activity, only inactivity armed
// R04 - linked: after inactivity, only activity armed
// R05 - linked: activity armed first after reset
// R06 - linked: next armed only after status read
// R07 - awake flag is one after reset
// R08 - inactivity seen and cleared drops awake
// R09 - activity seen and cleared raises awake
// R10 - linked referenced: reference updates on status read
// R11 - loop: like linked, self-clearing, no host
// R12 - loop: activity armed first after reset
// R13 - loop: awake set entering measurement mode
// R14 - host sets loop start activity threshold low
// R15 - host sets loop start inactivity threshold high
// R16 - 0x3f enables referenced detectors in loop
// R17 - 0x07 at 0x2d: measure with autosleep
// R18 - awake drops after start-up delay plus sample
// R19 - autosleep: wake-up on inactivity, measure on activity
// R20 - default mode ignores autosleep
// R21 - no autosleep with low noise selected
// R22 - awake may drive either event output
// R23 - sample buffer off in wake-up/autosleep
// R24 - referenced when either enable field is 11
// R25 - wake-up mode uses one-sample activity
// R26 - mode field change rearms activity
`timescale 1ns/10ps
`include "mls_consts.vh"
module mls_sequencer #(
  parameter STARTUP_CYCLES = `MLS_STARTUP_CYCLES
) (
  // clock and reset
  input wire clock,
  input wire rst,
  // register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // detector side
  input wire sample_tick,
  input wire act_raw,
  input wire inact_raw,
  // awake routing select
  input wire awake_to_a,
  input wire awake_to_b,
  // outputs to detectors and system
  output wire act_armed,
  output wire inact_armed,
  output wire referenced,
  output reg ref_update,
  output wire act_single_sample,
  output wire wakeup_mode,
  output wire buffer_enable,
  output wire [7:0] act_threshold,
  output wire [7:0] act_threshold_lo,
  output wire [7:0] act_time,
  output wire [15:0] inact_threshold,
  output wire [15:0] inact_time,
  output wire awake,
  output wire event_output_a,
  output wire event_output_b
);
  localparam ST_WAIT_ACT = 2'h0;
  localparam ST_WAIT_INACT = 2'h1;
  localparam ST_HELD_ACT = 2'h2;
  localparam ST_HELD_INACT = 2'h3;
  reg [7:0] activity_threshold_high;
  reg [7:0] activity_threshold_low;
  reg [7:0] activity_timer;
  reg [7:0] inactivity_threshold_high;
  reg [7:0] inactivity_threshold_low;
  reg [7:0] inactivity_timer_high;
  reg [7:0] inactivity_timer_low;
  reg [7:0] motion_link_control;
  reg [7:0] power_control;
  reg [1:0] state;
  reg [1:0] next_state;
  reg act_flag;
  reg inact_flag;
  reg awake_flag;
  reg next_awake;
  reg asleep_mode;
  reg next_asleep;
  reg startup_done;
  reg [31:0] startup_count;
  reg [1:0] prev_seq;
  wire [1:0] seq = motion_link_control[`MLS_LINKLOOP_LSB+1:`MLS_LINKLOOP_LSB];
  wire [1:0] activity_enable_field = motion_link_control[`MLS_ACTIVITY_ENABLE_FIELD_LSB+1:`MLS_ACTIVITY_ENABLE_FIELD_LSB];
  wire [1:0] inactivity_enable_field = motion_link_control[`MLS_INACTIVITY_ENABLE_FIELD_LSB+1:`MLS_INACTIVITY_ENABLE_FIELD_LSB];
  wire measuring = power_control[`MLS_MEAS_LSB+1:`MLS_MEAS_LSB] == `MLS_MEAS_ON;
  wire linked = seq == `MLS_SEQ_LINKED;
  wire looped = seq == `MLS_SEQ_LOOP;
  wire chained = linked | looped;
  // R20 R21
  wire autosleep = power_control[`MLS_AUTOSLEEP_BIT] & chained & ~power_control[`MLS_LOW_NOISE_BIT];
  wire status_rd = reg_rd & (reg_addr == `MLS_ADDR_STATUS);
  wire seq_changed = seq != prev_seq;
  // events only count once the first sample has arrived after entering measurement
  wire run = measuring & startup_done;
  // R01
  wire act_on = activity_enable_field[0] & run;
  wire inact_on = inactivity_enable_field[0] & run;
  // R02 R03 R04
  assign act_armed = act_on & (~chained | state == ST_WAIT_ACT);
  assign inact_armed = inact_on & (~chained | state == ST_WAIT_INACT);
  wire act_evt = act_armed & sample_tick & act_raw;
  wire inact_evt = inact_armed & sample_tick & inact_raw;
  // R24
  assign referenced = (activity_enable_field == `MLS_EN_REFERENCED) | (inactivity_enable_field == `MLS_EN_REFERENCED);
  assign wakeup_mode = asleep_mode;
  // R25
  assign act_single_sample = asleep_mode;
  // R23
  assign buffer_enable = measuring & ~asleep_mode & ~autosleep;
  assign act_threshold = activity_threshold_high;
  assign act_threshold_lo = activity_threshold_low;
  // R25
  assign act_time = asleep_mode ? 8'h00 : activity_timer;
  assign inact_threshold = {inactivity_threshold_high, inactivity_threshold_low};
  assign inact_time = {inactivity_timer_high, inactivity_timer_low};
  assign awake = awake_flag;
  // R22
  assign event_output_a = awake_to_a ? awake_flag : (act_flag | inact_flag);
  assign event_output_b = awake_to_b ? awake_flag : (act_flag | inact_flag);
  // register writes; R16 R17 are plain field decodes of these bytes
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      activity_threshold_high <= `MLS_RST_REG;
      activity_threshold_low <= `MLS_RST_REG;
      activity_timer <= `MLS_RST_REG;
      inactivity_threshold_high <= `MLS_RST_REG;
      inactivity_threshold_low <= `MLS_RST_REG;
      inactivity_timer_high <= `MLS_RST_REG;
      inactivity_timer_low <= `MLS_RST_REG;
      motion_link_control <= `MLS_RST_REG;
      power_control <= `MLS_RST_REG;
    end else if (reg_wr) begin
      case (reg_addr)
        `MLS_ADDR_ACT_THR_HI: activity_threshold_high <= reg_wdata;
        `MLS_ADDR_ACT_THR_LO: activity_threshold_low <= reg_wdata;
        `MLS_ADDR_ACT_TIMER: activity_timer <= reg_wdata;
        `MLS_ADDR_INACT_THR_HI: inactivity_threshold_high <= reg_wdata;
        `MLS_ADDR_INACT_THR_LO: inactivity_threshold_low <= reg_wdata;
        `MLS_ADDR_INACT_TMR_HI: inactivity_timer_high <= reg_wdata;
        `MLS_ADDR_INACT_TMR_LO: inactivity_timer_low <= reg_wdata;
        `MLS_ADDR_LINK_CTL: motion_link_control <= reg_wdata; // R16
        `MLS_ADDR_POWER_CONTROL: power_control <= reg_wdata; // R17
        default: ;
      endcase
    end
  end
  // start-up delay: first sample only after the delay and the next sample tick
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      startup_count <= 32'h0000_0000;
      startup_done <= 1'b0;
    end else if (!measuring) begin
      startup_count <= 32'h0000_0000;
      startup_done <= 1'b0;
    end else if (startup_count < STARTUP_CYCLES) begin
      startup_count <= startup_count + 32'h0000_0001;
    end else if (sample_tick) begin
      startup_done <= 1'b1; // R18
    end
  end
  // sequencing state
  always @* begin
    next_state = state;
    next_awake = awake_flag;
    next_asleep = asleep_mode;
    case (state)
      ST_WAIT_ACT: begin
        if (chained && act_evt) begin
          next_state = looped ? ST_WAIT_INACT : ST_HELD_ACT; // R03 R11
          if (looped) begin
            next_awake = 1'b1; // R09 R11
            next_asleep = 1'b0; // R19
          end
        end
      end
      ST_WAIT_INACT: begin
        if (chained && inact_evt) begin
          next_state = looped ? ST_WAIT_ACT : ST_HELD_INACT; // R04 R11
          if (looped) begin
            next_awake = 1'b0; // R08 R11
            next_asleep = autosleep; // R19
          end
        end
      end
      ST_HELD_ACT: begin
        if (status_rd) begin
          next_state = ST_WAIT_INACT; // R06
          next_awake = 1'b1; // R09
          next_asleep = 1'b0; // R19
        end
      end
      ST_HELD_INACT: begin
        if (status_rd) begin
          next_state = ST_WAIT_ACT; // R06
          next_awake = 1'b0; // R08
          next_asleep = autosleep; // R19
        end
      end
      default: next_state = ST_WAIT_ACT;
    endcase
    // default mode: awake follows serviced events
    if (!chained) begin
      next_state = ST_WAIT_ACT;
      next_asleep = 1'b0; // R20
      if (status_rd && inact_flag) next_awake = 1'b0; // R08
      if (status_rd && act_flag) next_awake = 1'b1; // R09
    end
    if (seq_changed || !measuring) begin
      next_state = ST_WAIT_ACT; // R05 R12 R26
      next_asleep = 1'b0;
    end
    if (!autosleep) next_asleep = 1'b0; // R21
    if (measuring && !startup_done && looped) next_awake = 1'b1; // R13
  end
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= ST_WAIT_ACT; // R05 R12
      awake_flag <= `MLS_AWAKE_RESET; // R07
      asleep_mode <= 1'b0;
      prev_seq <= `MLS_SEQ_DEFAULT;
    end else begin
      state <= next_state;
      awake_flag <= next_awake;
      asleep_mode <= next_asleep;
      prev_seq <= seq;
    end
  end
  // event flags: set wins over the clear of a status read; loop mode self-clears
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      act_flag <= 1'b0;
      inact_flag <= 1'b0;
    end else begin
      if (act_evt) act_flag <= 1'b1; // R02
      else if (status_rd || looped) act_flag <= 1'b0; // R02 R11
      if (inact_evt) inact_flag <= 1'b1; // R02
      else if (status_rd || looped) inact_flag <= 1'b0; // R02 R11
    end
  end
  // reference refresh pulse; linked mode refreshes only on status reads
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ref_update <= 1'b0;
    end else begin
      ref_update <= referenced & run & (linked ? status_rd : (act_evt | inact_evt)); // R10
    end
  end
  // register read data
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `MLS_ADDR_ACT_THR_HI: reg_rdata <= activity_threshold_high;
        `MLS_ADDR_ACT_THR_LO: reg_rdata <= activity_threshold_low;
        `MLS_ADDR_ACT_TIMER: reg_rdata <= activity_timer;
        `MLS_ADDR_INACT_THR_HI: reg_rdata <= inactivity_threshold_high;
        `MLS_ADDR_INACT_THR_LO: reg_rdata <= inactivity_threshold_low;
        `MLS_ADDR_INACT_TMR_HI: reg_rdata <= inactivity_timer_high;
        `MLS_ADDR_INACT_TMR_LO: reg_rdata <= inactivity_timer_low;
        `MLS_ADDR_LINK_CTL: reg_rdata <= motion_link_control;
        `MLS_ADDR_POWER_CONTROL: reg_rdata <= power_control;
        `MLS_ADDR_STATUS: reg_rdata <= {1'b0, awake_flag, inact_flag, act_flag, 4'h0};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule // mls_sequencer

// ==== dv/mls_det_model.sv ====
// detector-side stand-in: sample ticks and comparator levels
// assumes the sequencer clock; the bench chooses the comparator levels
`timescale 1ns/10ps
module mls_det_model #(parameter int TICK = 8) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // levels chosen by the bench
  input wire logic act_lvl,
  input wire logic inact_lvl,
  // to the sequencer
  output logic sample_tick,
  output logic act_raw,
  output logic inact_raw
);
  int cnt;
  // levels are registered so they move on the same clock edges as the tick, including the edge that raises it
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      sample_tick <= 1'b0;
      act_raw <= 1'b0;
      inact_raw <= 1'b0;
    end else begin
      cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
      sample_tick <= (cnt == TICK - 1);
      act_raw <= act_lvl;
      inact_raw <= inact_lvl;
    end
  end
endmodule // mls_det_model

// ==== dv/mls_sequencer_chk.sv ====
// port checker for the motion link sequencer
// assumes binding to mls_sequencer; shadows control writes itself
`timescale 1ns/10ps
module mls_sequencer_chk (
  // clock and reset
  input wire clock,
  input wire rst,
  // register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  // sequencer outputs and routing
  input wire act_armed,
  input wire inact_armed,
  input wire referenced,
  input wire act_single_sample,
  input wire wakeup_mode,
  input wire buffer_enable,
  input wire [7:0] act_time,
  input wire awake,
  input wire awake_to_a,
  input wire awake_to_b,
  input wire event_output_a,
  input wire event_output_b
);
  reg [7:0] ctl;
  reg [7:0] pwr;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ctl <= 8'h00;
      pwr <= 8'h00;
    end else begin
      ctl <= (reg_wr && reg_addr == 8'h27) ? reg_wdata : ctl;
      pwr <= (reg_wr && reg_addr == 8'h2d) ? reg_wdata : pwr;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_awake_rst;
    $past(rst) |-> awake;
  endproperty
  a_awake_rst: assert property (p_awake_rst) else $error("awake low after reset");
  property p_one_armed;
    ctl[4] |-> !(act_armed && inact_armed);
  endproperty
  a_one_armed: assert property (p_one_armed) else $error("both detectors armed");
  property p_ref;
    referenced == (ctl[1:0] == 2'h3 || ctl[3:2] == 2'h3);
  endproperty
  a_ref: assert property (p_ref) else $error("referenced flag wrong");
  property p_route_a;
    awake_to_a |-> event_output_a == awake;
  endproperty
  a_route_a: assert property (p_route_a) else $error("output a not awake");
  property p_route_b;
    awake_to_b |-> event_output_b == awake;
  endproperty
  a_route_b: assert property (p_route_b) else $error("output b not awake");
  property p_buf;
    (wakeup_mode || (pwr[2] && ctl[4] && !pwr[4])) |-> !buffer_enable;
  endproperty
  a_buf: assert property (p_buf) else $error("buffer on while asleep");
  property p_one_sample;
    wakeup_mode |-> act_single_sample && act_time == 8'h00;
  endproperty
  a_one_sample: assert property (p_one_sample) else $error("activity timer used in wake-up");
  // a fresh enable write may arm without a read, so only a steady field counts
  property p_rearm;
    ctl[5:4] == 2'h1 && $stable(ctl) && $rose(inact_armed) |-> $past(reg_rd && reg_addr == 8'h0b);
  endproperty
  a_rearm: assert property (p_rearm) else $error("armed without status read");
endmodule // mls_sequencer_chk
bind mls_sequencer mls_sequencer_chk i_mls_sequencer_chk (.clock(clock), .rst(rst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .act_armed(act_armed), .inact_armed(inact_armed),
  .referenced(referenced), .act_single_sample(act_single_sample), .wakeup_mode(wakeup_mode),
  .buffer_enable(buffer_enable), .act_time(act_time), .awake(awake), .awake_to_a(awake_to_a),
  .awake_to_b(awake_to_b), .event_output_a(event_output_a), .event_output_b(event_output_b));

// ==== dv/motion_link_sequencer_tb_top.sv ====
// self-checking bench for the motion link sequencer
// assumes the sequencer, its checker bind and the detector model are compiled first
`timescale 1ns/10ps
module motion_link_sequencer_tb_top;
  localparam int TICK = 8;
  logic clock = 0;
  logic rst = 1;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic awake_to_a = 0;
  logic awake_to_b = 0;
  logic act_lvl = 0;
  logic inact_lvl = 0;
  logic pend = 0;
  logic [7:0] exp_q[$];
  logic [7:0] v;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;
  wire [7:0] reg_rdata, act_threshold, act_threshold_lo, act_time;
  wire [15:0] inact_threshold, inact_time;
  wire sample_tick, act_raw, inact_raw, act_armed, inact_armed, referenced, wakeup_mode, buffer_enable, awake;
  mls_det_model #(.TICK(TICK)) i_mls_det_model (.clock(clock), .rst(rst), .act_lvl(act_lvl), .inact_lvl(inact_lvl),
    .sample_tick(sample_tick), .act_raw(act_raw), .inact_raw(inact_raw));
  // short start-up count keeps the run brief
  mls_sequencer #(.STARTUP_CYCLES(20)) i_mls_sequencer (.clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_tick(sample_tick), .act_raw(act_raw),
    .inact_raw(inact_raw), .awake_to_a(awake_to_a), .awake_to_b(awake_to_b), .act_armed(act_armed),
    .inact_armed(inact_armed), .referenced(referenced), .ref_update(), .act_single_sample(), .wakeup_mode(wakeup_mode),
    .buffer_enable(buffer_enable), .act_threshold(act_threshold), .act_threshold_lo(act_threshold_lo),
    .act_time(act_time), .inact_threshold(inact_threshold), .inact_time(inact_time), .awake(awake),
    .event_output_a(), .event_output_b());
  always #5 clock = ~clock;
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic finish_test();
    if (err_total == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) #1;
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock) #1;
    reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock) #1;
    reg_rd = 1;
    reg_addr = a;
    exp_q.push_back(e);
    @(posedge clock) #1;
    reg_rd = 0;
  endtask
  task automatic settle(input logic a, input logic i);
    #1;
    act_lvl = a;
    inact_lvl = i;
    repeat (3 * TICK) @(posedge clock);
  endtask
  // read data lands one cycle after the read edge
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (pend) check(reg_rdata, exp_q.pop_front());
    pend <= reg_rd;
    if (cyc == 6000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(32'h1843));
    repeat (12) @(posedge clock);
    #1;
    rst = 0;
    v = 8'($urandom);
    awake_to_a = v[0];
    awake_to_b = v[1];
    rd(8'h0b, 8'h40);
    for (int i = 0; i < 9; i++) rd((i == 8) ? 8'h2d : 8'h20 + 8'(i), 8'h00);
    wr(8'h3a, 8'hff);
    rd(8'h3a, 8'h00);
    for (int i = 0; i < 7; i++) begin
      v = 8'($urandom);
      wr(8'h20 + 8'(i), v);
      rd(8'h20 + 8'(i), v);
    end
    for (int i = 0; i < 16; i++) begin
      wr(8'h27, 8'(i));
      check(referenced, (i[1:0] == 2'h3 || i[3:2] == 2'h3));
    end
    wr(8'h20, 8'h00);
    wr(8'h21, 8'h04);
    wr(8'h22, 8'h00);
    wr(8'h23, 8'h7f);
    wr(8'h24, 8'hfc);
    wr(8'h25, 8'h00);
    wr(8'h26, 8'h00);
    check(inact_threshold, 16'h7ffc);
    check(inact_time, 16'h0000);
    check(act_threshold, 8'h00);
    check(act_threshold_lo, 8'h04);
    check(act_time, 8'h00);
    wr(8'h2d, 8'h07);
    wr(8'h27, 8'h15);
    // detectors stay idle until the start-up count and one sample have passed
    repeat (40) @(posedge clock);
    #1;
    check(act_armed, 1'b1);
    check(inact_armed, 1'b0);
    settle(1'b1, 1'b0);
    check(inact_armed, 1'b0);
    rd(8'h0b, 8'h50);
    check(inact_armed, 1'b1);
    check(act_armed, 1'b0);
    settle(1'b0, 1'b1);
    rd(8'h0b, 8'h60);
    check(awake, 1'b0);
    check(act_armed, 1'b1);
    check(wakeup_mode, 1'b1);
    check(act_time, 8'h00);
    settle(1'b1, 1'b0);
    rd(8'h0b, 8'h10);
    check(awake, 1'b1);
    check(wakeup_mode, 1'b0);
    wr(8'h2d, 8'h00);
    act_lvl = 1;
    inact_lvl = 1;
    wr(8'h27, 8'h3f);
    wr(8'h2d, 8'h07);
    check(awake, 1'b1);
    for (n = 0; n < 300 && awake !== 1'b0; n++) @(posedge clock);
    #1;
    check(awake, 1'b0);
    check(n >= 20, 1'b1);
    check(wakeup_mode, 1'b1);
    check(buffer_enable, 1'b0);
    rd(8'h0b, 8'h00);
    settle(1'b1, 1'b0);
    check(awake, 1'b1);
    check(wakeup_mode, 1'b0);
    repeat (2) @(posedge clock);
    finish_test();
  end
endmodule // motion_link_sequencer_tb_top
